// ---- verilog/otpps_defs.svh ----
// Timing constants and limits for the one-time programmable byte programmer
`ifndef OTPPS_DEFS_SVH
`define OTPPS_DEFS_SVH

// Clock period
`define OTPPS_CLK_NS        10
// Program pulse width, nominal, least and longest
`define OTPPS_TPW_NS        50000
`define OTPPS_TPW_MIN_NS    47500
`define OTPPS_TPW_MAX_NS    52500
`define OTPPS_TPW_CYC       (`OTPPS_TPW_NS / `OTPPS_CLK_NS)
`define OTPPS_TPW_MIN_CYC   ((`OTPPS_TPW_MIN_NS + `OTPPS_CLK_NS - 1) / `OTPPS_CLK_NS)
`define OTPPS_TPW_MAX_CYC   (`OTPPS_TPW_MAX_NS / `OTPPS_CLK_NS)
// Setup, hold and recovery times, all least times
`define OTPPS_TSET_NS       2000
`define OTPPS_TSET_CYC      ((`OTPPS_TSET_NS + `OTPPS_CLK_NS - 1) / `OTPPS_CLK_NS)
`define OTPPS_TLAH_NS       100
`define OTPPS_TLAH_CYC      ((`OTPPS_TLAH_NS + `OTPPS_CLK_NS - 1) / `OTPPS_CLK_NS)
// Data valid after output enable, float after release
`define OTPPS_TOE_NS        150
`define OTPPS_TOE_CYC       ((`OTPPS_TOE_NS + `OTPPS_CLK_NS - 1) / `OTPPS_CLK_NS)
`define OTPPS_TDFP_NS       130
`define OTPPS_TDFP_CYC      ((`OTPPS_TDFP_NS + `OTPPS_CLK_NS - 1) / `OTPPS_CLK_NS)
// Retry pulses allowed per byte
`define OTPPS_MAX_RETRY     10
// Bit of the upper address lines that selects the identification byte
`define OTPPS_ID_SEL_BIT    0

`endif

// ---- verilog/otpps_pkg.sv ----
// Types shared by the programmer modules
`default_nettype none

package otpps_pkg;

  typedef enum logic [4:0] {
    ST_IDLE, ST_VCC_UP, ST_VPP_UP, ST_ID_UP, ST_ALE, ST_LATCH, ST_DSET, ST_PULSE,
    ST_DHOLD, ST_VDROP, ST_VRISE, ST_OE, ST_FLOAT, ST_CHECK, ST_PUSH, ST_VCC_NOM,
    ST_SHUT, ST_OFF
  } otpps_state_t;

  typedef enum logic [1:0] {
    MD_PASS1, MD_VERIFY, MD_READBACK, MD_IDENT
  } otpps_mode_t;

endpackage : otpps_pkg

`default_nettype wire

// ---- verilog/otpps_fifo.sv ----
// Small FIFO with registered read data and valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module otpps_fifo #(
  parameter int DW = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          arst_n,
  // Fill side
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [DW-1:0] in_data,
  // Drain side
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [DW-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   cnt_q;
  logic          ov_q;
  logic [DW-1:0] od_q;

  wire push = in_valid && in_ready;
  wire load = (cnt_q != '0) && (!ov_q || out_ready);

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = ov_q;
  assign out_data  = od_q;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // Head word moves into an output register so the read data never come from the array
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
      ov_q     <= 1'b0;
      od_q     <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (load) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
        od_q     <= mem[rd_ptr_q];
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
      if (load) begin
        ov_q <= 1'b1;
      end else if (out_ready) begin
        ov_q <= 1'b0;
      end
    end
  end

endmodule : otpps_fifo

`default_nettype wire

// ---- verilog/otpps_ctrl.sv ----
// Programming controller for a byte-wide OTP memory with multiplexed address/data lines
// Function
// - Each program pulse on the latch strobe lasts 50 us, within 47.5 to 52.5 us.
// - Start at address zero, programming core supply, then high program voltage.
// - First pass gives every address exactly one pulse, no verify reads.
// - Then verify each address; on mismatch add single pulses, verify after each.
// - A byte still failing after ten retry pulses stops and fails the part.
// - A verified byte moves on to the next address until all are checked.
// - Drop program voltage and core supply, read all back, compare, report.
// - Core supply on no later than program voltage, off no earlier.
// - Identification holds upper lines low, high-voltage line elevated, toggles select.
`timescale 1ns/1ps
`default_nettype none
`include "otpps_defs.svh"

module otpps_ctrl #(
  parameter int AW = 16,
  parameter int PW_CYC = `OTPPS_TPW_CYC,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          arst_n,
  // Commands and source data
  input  wire logic          start_prog,
  input  wire logic          start_id,
  input  wire logic [AW-1:0] last_addr,
  input  wire logic [7:0]    src_data,
  output logic [AW-1:0]      src_addr_q,
  // Status
  output logic               busy_q,
  output logic               done_q,
  output logic               pass_q,
  output logic               fail_q,
  output logic [7:0]         id_mfr_q,
  output logic [7:0]         id_dev_q,
  // Read-back stream
  output logic               rb_valid_q,
  input  wire logic          rb_ready,
  output logic [7:0]         rb_data_q,
  // Memory pins
  output logic [7:0]         muxed_addr_data_lines_o_q,
  output logic               muxed_addr_data_lines_oe_n_q,
  input  wire logic [7:0]    muxed_addr_data_lines_i,
  output logic [7:0]         upper_address_lines_q,
  output logic               ale_q,
  output logic               oe_n_q,
  output logic               vpp_hv_q,
  output logic               vcc_on_q,
  output logic               vcc_prog_q,
  output logic               id_high_voltage_line_q
);

  // ==========================================================
  // Timing
  // Limits scale with PW_CYC, so a shortened pulse keeps the same five percent tolerance
  localparam int TPW_MIN = (`OTPPS_TPW_MIN_CYC * PW_CYC + `OTPPS_TPW_CYC - 1) / `OTPPS_TPW_CYC;
  localparam int TPW_MAX = (`OTPPS_TPW_MAX_CYC * PW_CYC) / `OTPPS_TPW_CYC;
  localparam logic [3:0] MAX_RETRY = 4'(`OTPPS_MAX_RETRY);

  function automatic logic [15:0] wait_of(input otpps_pkg::otpps_state_t s);
    case (s)
      otpps_pkg::ST_PULSE: wait_of = 16'(PW_CYC - 1);
      otpps_pkg::ST_LATCH: wait_of = 16'(`OTPPS_TLAH_CYC - 1);
      otpps_pkg::ST_OE:    wait_of = 16'(`OTPPS_TOE_CYC - 1);
      otpps_pkg::ST_FLOAT: wait_of = 16'(`OTPPS_TDFP_CYC - 1);
      otpps_pkg::ST_VCC_UP, otpps_pkg::ST_VPP_UP, otpps_pkg::ST_ID_UP, otpps_pkg::ST_ALE,
      otpps_pkg::ST_DSET, otpps_pkg::ST_DHOLD, otpps_pkg::ST_VDROP, otpps_pkg::ST_VRISE,
      otpps_pkg::ST_VCC_NOM, otpps_pkg::ST_SHUT: wait_of = 16'(`OTPPS_TSET_CYC - 1);
      default: wait_of = 16'h0000;
    endcase
  endfunction : wait_of

  // ==========================================================
  // State
  otpps_pkg::otpps_state_t st_q, st_d;
  otpps_pkg::otpps_mode_t  md_q, md_d;
  logic [15:0]   tmr_q, tmr_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [3:0]    retry_q, retry_d;
  logic          prg_q, prg_d;
  logic          sel_q, sel_d;
  logic          bad_q, bad_d;
  logic [7:0]    rd_q, rd_d;
  logic          done_d, pass_d, fail_d;
  logic [7:0]    mfr_d, dev_d;

  wire tmr_zero  = (tmr_q == 16'h0000);
  wire is_last   = (addr_q == last_addr);
  wire match     = (rd_q == src_data);
  wire fifo_in_ready;
  wire fifo_push = (st_q == otpps_pkg::ST_PUSH);

  always_comb begin
    st_d    = st_q;
    md_d    = md_q;
    addr_d  = addr_q;
    retry_d = retry_q;
    prg_d   = prg_q;
    sel_d   = sel_q;
    bad_d   = bad_q;
    rd_d    = rd_q;
    done_d  = 1'b0;
    pass_d  = pass_q;
    fail_d  = fail_q;
    mfr_d   = id_mfr_q;
    dev_d   = id_dev_q;
    case (st_q)
      otpps_pkg::ST_IDLE: begin
        addr_d  = '0;
        retry_d = 4'h0;
        bad_d   = 1'b0;
        sel_d   = 1'b0;
        if (start_prog) begin
          md_d   = otpps_pkg::MD_PASS1;
          prg_d  = 1'b1;
          pass_d = 1'b0;
          fail_d = 1'b0;
          st_d   = otpps_pkg::ST_VCC_UP;
        end else if (start_id) begin
          md_d  = otpps_pkg::MD_IDENT;
          prg_d = 1'b0;
          st_d  = otpps_pkg::ST_ID_UP;
        end
      end
      otpps_pkg::ST_VCC_UP:  if (tmr_zero) st_d = otpps_pkg::ST_VPP_UP;
      otpps_pkg::ST_VPP_UP:  if (tmr_zero) st_d = otpps_pkg::ST_ALE;
      otpps_pkg::ST_ID_UP:   if (tmr_zero) st_d = otpps_pkg::ST_ALE;
      otpps_pkg::ST_ALE:     if (tmr_zero) st_d = otpps_pkg::ST_LATCH;
      otpps_pkg::ST_LATCH: begin
        if (tmr_zero) st_d = prg_q ? otpps_pkg::ST_DSET : otpps_pkg::ST_OE;
      end
      otpps_pkg::ST_DSET:    if (tmr_zero) st_d = otpps_pkg::ST_PULSE;
      otpps_pkg::ST_PULSE:   if (tmr_zero) st_d = otpps_pkg::ST_DHOLD;
      otpps_pkg::ST_DHOLD: begin
        if (tmr_zero) begin
          prg_d = 1'b0;
          st_d  = otpps_pkg::ST_VDROP;
          if (md_q == otpps_pkg::MD_PASS1) begin
            if (is_last) begin
              addr_d = '0;
              md_d   = otpps_pkg::MD_VERIFY;
            end else begin
              addr_d = addr_q + 1'b1;
              prg_d  = 1'b1;
              st_d   = otpps_pkg::ST_ALE;
            end
          end
        end
      end
      otpps_pkg::ST_VDROP:   if (tmr_zero) st_d = otpps_pkg::ST_ALE;
      otpps_pkg::ST_VRISE:   if (tmr_zero) st_d = otpps_pkg::ST_ALE;
      otpps_pkg::ST_OE: begin
        if (tmr_zero) begin
          rd_d = muxed_addr_data_lines_i;
          st_d = otpps_pkg::ST_FLOAT;
        end
      end
      otpps_pkg::ST_FLOAT: begin
        if (tmr_zero) st_d = (md_q == otpps_pkg::MD_READBACK) ? otpps_pkg::ST_PUSH
                                                                : otpps_pkg::ST_CHECK;
      end
      otpps_pkg::ST_CHECK: begin
        if (md_q == otpps_pkg::MD_IDENT) begin
          if (!sel_q) begin
            mfr_d = rd_q;
            sel_d = 1'b1;
            st_d  = otpps_pkg::ST_ALE;
          end else begin
            dev_d = rd_q;
            st_d  = otpps_pkg::ST_SHUT;
          end
        end else if (match) begin
          retry_d = 4'h0;
          if (is_last) begin
            addr_d = '0;
            st_d   = otpps_pkg::ST_VCC_NOM;
          end else begin
            addr_d = addr_q + 1'b1;
            st_d   = otpps_pkg::ST_VDROP;
          end
        end else if (retry_q == MAX_RETRY) begin
          fail_d = 1'b1;
          st_d   = otpps_pkg::ST_SHUT;
        end else begin
          retry_d = retry_q + 1'b1;
          prg_d   = 1'b1;
          st_d    = otpps_pkg::ST_VRISE;
        end
      end
      otpps_pkg::ST_VCC_NOM: begin
        if (tmr_zero) begin
          md_d = otpps_pkg::MD_READBACK;
          st_d = otpps_pkg::ST_ALE;
        end
      end
      otpps_pkg::ST_PUSH: begin
        if (fifo_in_ready) begin
          if (!match) bad_d = 1'b1;
          if (is_last) begin
            st_d = otpps_pkg::ST_SHUT;
          end else begin
            addr_d = addr_q + 1'b1;
            st_d   = otpps_pkg::ST_ALE;
          end
        end
      end
      otpps_pkg::ST_SHUT:    if (tmr_zero) st_d = otpps_pkg::ST_OFF;
      otpps_pkg::ST_OFF: begin
        done_d = 1'b1;
        if (md_q == otpps_pkg::MD_READBACK) begin
          pass_d = !bad_q;
          fail_d = bad_q;
        end
        st_d = otpps_pkg::ST_IDLE;
      end
      default: st_d = otpps_pkg::ST_IDLE;
    endcase
  end

  // ==========================================================
  // Pin levels, decoded from the next state so each pin leaves a flip-flop
  wire in_prog = (md_d == otpps_pkg::MD_PASS1) || (md_d == otpps_pkg::MD_VERIFY);
  wire vcc_d   = (st_d != otpps_pkg::ST_IDLE) && (st_d != otpps_pkg::ST_OFF);
  // Supply leaves the programming level only after the high voltage is gone
  wire vprog_d = vcc_d && in_prog && (st_d != otpps_pkg::ST_VCC_NOM)
                 && (st_d != otpps_pkg::ST_SHUT || vcc_prog_q);
  wire vpp_d   = in_prog && prg_d && !(st_d inside {otpps_pkg::ST_IDLE, otpps_pkg::ST_VCC_UP,
                 otpps_pkg::ST_VDROP, otpps_pkg::ST_SHUT, otpps_pkg::ST_OFF});
  wire ale_d   = (st_d == otpps_pkg::ST_ALE) || (st_d == otpps_pkg::ST_PULSE)
                 || !vcc_d;
  wire oe_n_d  = (st_d != otpps_pkg::ST_OE);
  wire drv_n_d = !vcc_d || (st_d inside {otpps_pkg::ST_OE, otpps_pkg::ST_FLOAT,
                 otpps_pkg::ST_CHECK, otpps_pkg::ST_PUSH});
  wire idhv_d  = (md_d == otpps_pkg::MD_IDENT) && vcc_d && (st_d != otpps_pkg::ST_SHUT);
  wire [7:0] ad_d = (st_d inside {otpps_pkg::ST_DSET, otpps_pkg::ST_PULSE,
                    otpps_pkg::ST_DHOLD}) ? src_data : addr_d[7:0];
  wire [7:0] ua_d = (md_d == otpps_pkg::MD_IDENT) ?
                    (8'h00 | (8'(sel_d) << `OTPPS_ID_SEL_BIT)) : 8'(addr_d >> 8);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q    <= otpps_pkg::ST_IDLE;
      md_q    <= otpps_pkg::MD_PASS1;
      tmr_q   <= 16'h0000;
      addr_q  <= '0;
      retry_q <= 4'h0;
      prg_q   <= 1'b0;
      sel_q   <= 1'b0;
      bad_q   <= 1'b0;
      rd_q    <= 8'h00;
    end else begin
      st_q    <= st_d;
      md_q    <= md_d;
      tmr_q   <= (st_d != st_q) ? wait_of(st_d) : (tmr_zero ? tmr_q : tmr_q - 1'b1);
      addr_q  <= addr_d;
      retry_q <= retry_d;
      prg_q   <= prg_d;
      sel_q   <= sel_d;
      bad_q   <= bad_d;
      rd_q    <= rd_d;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      pass_q <= 1'b0;
      fail_q <= 1'b0;
      id_mfr_q <= 8'h00;
      id_dev_q <= 8'h00;
      src_addr_q <= '0;
    end else begin
      busy_q <= (st_d != otpps_pkg::ST_IDLE);
      done_q <= done_d;
      pass_q <= pass_d;
      fail_q <= fail_d;
      id_mfr_q <= mfr_d;
      id_dev_q <= dev_d;
      src_addr_q <= addr_d;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      muxed_addr_data_lines_o_q    <= 8'h00;
      muxed_addr_data_lines_oe_n_q <= 1'b1;
      upper_address_lines_q        <= 8'h00;
      ale_q                        <= 1'b1;
      oe_n_q                       <= 1'b1;
      vpp_hv_q                     <= 1'b0;
      vcc_on_q                     <= 1'b0;
      vcc_prog_q                   <= 1'b0;
      id_high_voltage_line_q       <= 1'b0;
    end else begin
      muxed_addr_data_lines_o_q    <= ad_d;
      muxed_addr_data_lines_oe_n_q <= drv_n_d;
      upper_address_lines_q        <= ua_d;
      ale_q                        <= ale_d;
      oe_n_q                       <= oe_n_d;
      vpp_hv_q                     <= vpp_d;
      vcc_on_q                     <= vcc_d;
      vcc_prog_q                   <= vprog_d;
      id_high_voltage_line_q       <= idhv_d;
    end
  end

  // ==========================================================
  // Read-back buffer; a stalled drain holds the sequence in ST_PUSH
  otpps_fifo #(.DW(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (rd_q),
    .out_valid (rb_valid_q),
    .out_ready (rb_ready),
    .out_data  (rb_data_q)
  );

  // ==========================================================
  // Checks
  logic [15:0] pw_cnt_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) pw_cnt_q <= 16'h0000;
    else pw_cnt_q <= (st_q == otpps_pkg::ST_PULSE) ? pw_cnt_q + 1'b1 : 16'h0000;
  end

  a_pulse_width: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_q == otpps_pkg::ST_PULSE && st_d != otpps_pkg::ST_PULSE)
    |-> (32'(pw_cnt_q) + 1 >= TPW_MIN && 32'(pw_cnt_q) + 1 <= TPW_MAX))
    else $error("program pulse width out of range");
  a_prog_entry: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(vpp_hv_q) && md_q == otpps_pkg::MD_PASS1 && addr_q == '0 |-> vcc_prog_q)
    else $error("high voltage raised without programming supply");
  a_pass1_noread: assert property (@(posedge mclk) disable iff (!arst_n)
    md_q == otpps_pkg::MD_PASS1 |-> oe_n_q && retry_q == 4'h0)
    else $error("read or retry during first pass");
  a_retry_limit: assert property (@(posedge mclk) disable iff (!arst_n)
    retry_q <= MAX_RETRY)
    else $error("retry counter beyond limit");
  a_fail_stop: assert property (@(posedge mclk) disable iff (!arst_n)
    st_q == otpps_pkg::ST_CHECK && md_q == otpps_pkg::MD_VERIFY && !match
    && retry_q == MAX_RETRY |=> fail_d && st_q == otpps_pkg::ST_SHUT)
    else $error("exhausted byte did not fail the part");
  a_addr_advance: assert property (@(posedge mclk) disable iff (!arst_n)
    md_q == otpps_pkg::MD_VERIFY && st_q == otpps_pkg::ST_CHECK && !match
    |=> addr_q == $past(addr_q))
    else $error("address moved on a mismatch");
  a_readback_lv: assert property (@(posedge mclk) disable iff (!arst_n)
    md_q == otpps_pkg::MD_READBACK && !oe_n_q |-> !vpp_hv_q && !vcc_prog_q)
    else $error("read-back at programming levels");
  a_supply_order: assert property (@(posedge mclk) disable iff (!arst_n)
    (vpp_hv_q |-> vcc_on_q && vcc_prog_q) and ($fell(vcc_on_q) |-> !$past(vpp_hv_q)))
    else $error("supply sequencing violated");
  a_id_lines: assert property (@(posedge mclk) disable iff (!arst_n)
    id_high_voltage_line_q |-> (upper_address_lines_q >> 1) == 8'h00)
    else $error("upper lines not low in identification");
  a_retry_count: assert property (@(posedge mclk) disable iff (!arst_n)
    st_q == otpps_pkg::ST_CHECK && md_q == otpps_pkg::MD_VERIFY && !match
    && retry_q < MAX_RETRY |=> retry_q == $past(retry_q) + 4'h1)
    else $error("retry counter did not count");

endmodule : otpps_ctrl

`default_nettype wire

// ---- verification/otpps_mem_model.sv ----
// Behavioural one-time programmable memory seen from the programmer's pins
`timescale 1ns/1ps
`default_nettype none

module otpps_mem_model #(
  parameter int         PW_LO  = 99,
  parameter int         PW_HI  = 101,
  parameter logic [7:0] ID_MFR = 8'h3c,  // Arbitrary value
  parameter logic [7:0] ID_DEV = 8'hc3   // Arbitrary value
) (
  // Clock
  input  wire logic       mclk,
  // Programmer pins
  input  wire logic [7:0] lines_o,
  input  wire logic       lines_oe_n,
  input  wire logic [7:0] upper,
  input  wire logic       ale,
  input  wire logic       oe_n,
  input  wire logic       vpp_hv,
  input  wire logic       vcc_on,
  input  wire logic       vcc_prog,
  input  wire logic       id_hv,
  // Fault controls
  input  wire logic       wipe,
  input  wire logic [4:0] weak_addr,
  input  wire logic [4:0] weak_need,
  input  wire logic       rb_flip,
  // Resolved multiplexed lines
  output logic [7:0]      bus
);
  logic [7:0]  mem [32];
  int          pulses [32];
  logic [15:0] addr = 16'h0000;
  logic [7:0]  last = 8'h00;
  logic        ale_p = 1'b1;
  logic        oe_p = 1'b1;
  logic        hv_rise = 1'b0;
  logic        first_done = 1'b0;
  logic        reading;
  logic [7:0]  rd_val;
  int          hi_cnt = 0;
  int          n_reads = 0;
  int          viol = 0;

  // ==========================================================
  // Read path
  assign reading = !oe_n && !vpp_hv && !ale && vcc_on;
  assign rd_val  = id_hv ? (upper[0] ? ID_DEV : ID_MFR)
                 : mem[addr[4:0]] ^ {7'h00, rb_flip && !vcc_prog};
  // Released lines have no pull, so show a changing pattern instead of the old value
  assign bus = !lines_oe_n ? lines_o : (reading ? rd_val : ~last);

  // ==========================================================
  // Latch, program and pin-order watch
  always @(posedge mclk) begin
    int a;
    a = int'(addr[4:0]);
    last <= bus;
    if (wipe) begin
      foreach (mem[i]) mem[i] = 8'hff;
      foreach (pulses[i]) pulses[i] = 0;
      n_reads = 0;
      first_done = 1'b0;
    end
    if (vpp_hv && !vcc_on) viol++;
    if (ale && !ale_p) begin
      hv_rise = vpp_hv;
      hi_cnt = 0;
    end
    if (ale) hi_cnt++;
    // Latch strobes run longer than a program pulse, so width tells them apart
    if (!ale && ale_p) begin
      if (hv_rise && vpp_hv && hi_cnt < 150) begin
        if (pulses[a] == 0 && n_reads != 0) viol++;
        if (!first_done && (addr != 16'h0000 || !vcc_prog)) viol++;
        if (hi_cnt < PW_LO || hi_cnt > PW_HI) viol++;
        first_done = 1'b1;
        pulses[a]++;
        if (pulses[a] >= ((a == int'(weak_addr)) ? int'(weak_need) : 1)) mem[a] = mem[a] & bus;
      end else begin
        addr = {upper, bus};
      end
    end
    if (!oe_n && oe_p && reading) begin
      n_reads++;
      if (id_hv && upper[7:1] != 7'h00) viol++;
    end
    ale_p = ale;
    oe_p = oe_n;
  end
endmodule : otpps_mem_model

`default_nettype wire

// ---- verification/otpps_ctrl_bench.sv ----
// Self-checking bench for the OTP programming controller
`timescale 1ns/1ps
`default_nettype none

module otpps_ctrl_bench;
  localparam int         PW   = 100;
  localparam logic [7:0] ID_M = 8'h3c;  // Arbitrary value
  localparam logic [7:0] ID_D = 8'hc3;  // Arbitrary value
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        start_prog = 1'b0;
  logic        start_id = 1'b0;
  logic [15:0] last_addr = 16'h0000;
  logic [15:0] src_addr_q;
  logic [7:0]  src_data, id_mfr_q, id_dev_q, rb_data_q, lines_o, lines_i, upper;
  logic        busy_q, done_q, pass_q, fail_q, rb_valid_q, lines_oe_n, ale, oe_n;
  logic        vpp_hv, vcc_on, vcc_prog, id_hv, got_done;
  logic        rb_ready = 1'b1;
  logic        wipe = 1'b0;
  logic        rb_flip = 1'b0;
  logic [4:0]  weak_addr = 5'h1f;
  logic [4:0]  weak_need = 5'h01;
  logic [7:0]  rbq [$];
  int          mismatches = 0;
  int          n_checks = 0;
  int          cyc = 0;

  function automatic logic [7:0] exp_byte(input logic [15:0] a);
    return {a[3:0], ~a[3:0]} ^ 8'h21;
  endfunction : exp_byte

  always #5 mclk = ~mclk;
  assign src_data = exp_byte(src_addr_q);

  otpps_ctrl #(.PW_CYC(PW)) otpps_ctrl_inst (
    .mclk(mclk), .arst_n(arst_n), .start_prog(start_prog), .start_id(start_id),
    .last_addr(last_addr), .src_data(src_data), .src_addr_q(src_addr_q),
    .busy_q(busy_q), .done_q(done_q), .pass_q(pass_q), .fail_q(fail_q),
    .id_mfr_q(id_mfr_q), .id_dev_q(id_dev_q), .rb_valid_q(rb_valid_q),
    .rb_ready(rb_ready), .rb_data_q(rb_data_q), .muxed_addr_data_lines_o_q(lines_o),
    .muxed_addr_data_lines_oe_n_q(lines_oe_n), .muxed_addr_data_lines_i(lines_i),
    .upper_address_lines_q(upper), .ale_q(ale), .oe_n_q(oe_n), .vpp_hv_q(vpp_hv),
    .vcc_on_q(vcc_on), .vcc_prog_q(vcc_prog), .id_high_voltage_line_q(id_hv)
  );

  otpps_mem_model #(.PW_LO(PW - 1), .PW_HI(PW + 1), .ID_MFR(ID_M), .ID_DEV(ID_D))
  otpps_mem_model_inst (
    .mclk(mclk), .lines_o(lines_o), .lines_oe_n(lines_oe_n), .upper(upper), .ale(ale),
    .oe_n(oe_n), .vpp_hv(vpp_hv), .vcc_on(vcc_on), .vcc_prog(vcc_prog), .id_hv(id_hv),
    .wipe(wipe), .weak_addr(weak_addr), .weak_need(weak_need), .rb_flip(rb_flip),
    .bus(lines_i)
  );

  // ==========================================================
  // Collector and hang guard
  always @(posedge mclk) begin
    if (rb_valid_q === 1'b1 && rb_ready === 1'b1) rbq.push_back(rb_data_q);
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 100000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_done(input int bound);
    int n;
    n = 0;
    while (done_q !== 1'b1 && n < bound) begin
      @(posedge mclk);
      #1 n++;
    end
    got_done = (done_q === 1'b1);
  endtask : wait_done

  task automatic run_prog(input logic [15:0] last, input logic [4:0] wa, input logic [4:0] wn,
                          input logic flip);
    repeat (2) @(posedge mclk);
    #1 rbq.delete();
    last_addr = last;
    weak_addr = wa;
    weak_need = wn;
    rb_flip = flip;
    wipe = 1'b1;
    @(posedge mclk);
    #1 wipe = 1'b0;
    start_prog = 1'b1;
    @(posedge mclk);
    #1 start_prog = 1'b0;
  endtask : run_prog

  // Bytes from 5 V reads come back with bit 0 flipped when the fault is on
  task automatic check_end(input logic pass, input int nrb);
    check("done", {15'h0000, got_done}, 16'h0001);
    check("busy after done", {15'h0000, busy_q}, 16'h0000);
    check("pass", {15'h0000, pass_q}, {15'h0000, pass});
    check("fail", {15'h0000, fail_q}, {15'h0000, ~pass});
    check("readback count", 16'(rbq.size()), 16'(nrb));
    foreach (rbq[i]) begin
      check("readback", {8'h00, rbq[i]},
            {8'h00, exp_byte(16'(i)) ^ {7'h00, rb_flip}});
    end
    check("pin order", 16'(otpps_mem_model_inst.viol), 16'h0000);
  endtask : check_end

  // ==========================================================
  // Scenarios
  task automatic t_normal;
    rb_ready = 1'b0;
    run_prog(16'h0011, 5'h1f, 5'h01, 1'b0);
    wait_done(30000);
    check("done while stalled", {15'h0000, got_done}, 16'h0000);
    check("busy while stalled", {15'h0000, busy_q}, 16'h0001);
    rb_ready = 1'b1;
    wait_done(4000);
    check_end(1'b1, 18);
    for (int i = 0; i < 18; i++) begin
      check("pulses", 16'(otpps_mem_model_inst.pulses[i]), 16'h0001);
    end
    $display("test normal done");
  endtask : t_normal

  task automatic t_limit;
    run_prog(16'h0001, 5'h00, 5'h0b, 1'b0);
    wait_done(20000);
    check_end(1'b1, 2);
    check("pulses at limit", 16'(otpps_mem_model_inst.pulses[0]), 16'h000b);
    check("pulses next", 16'(otpps_mem_model_inst.pulses[1]), 16'h0001);
    $display("test limit done");
  endtask : t_limit

  task automatic t_exhaust;
    run_prog(16'h0001, 5'h00, 5'h0c, 1'b0);
    wait_done(20000);
    check_end(1'b0, 0);
    check("pulses failed", 16'(otpps_mem_model_inst.pulses[0]), 16'h000b);
    check("pulses after stop", 16'(otpps_mem_model_inst.pulses[1]), 16'h0001);
    $display("test exhaust done");
  endtask : t_exhaust

  task automatic t_flip;
    run_prog(16'h0001, 5'h1f, 5'h01, 1'b1);
    wait_done(8000);
    check_end(1'b0, 2);
    rb_flip = 1'b0;
    $display("test readback fault done");
  endtask : t_flip

  task automatic t_ident;
    repeat (2) @(posedge mclk);
    #1 start_id = 1'b1;
    @(posedge mclk);
    #1 start_id = 1'b0;
    wait_done(4000);
    check("id done", {15'h0000, got_done}, 16'h0001);
    check("maker byte", {8'h00, id_mfr_q}, {8'h00, ID_M});
    check("type byte", {8'h00, id_dev_q}, {8'h00, ID_D});
    check("id pin order", 16'(otpps_mem_model_inst.viol), 16'h0000);
    $display("test ident done");
  endtask : t_ident

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (2) @(posedge mclk);
    #1 arst_n = 1'b1;
    t_normal();
    t_limit();
    t_exhaust();
    t_flip();
    t_ident();
    wrap_up();
  end
endmodule : otpps_ctrl_bench

`default_nettype wire
